/* core/i2c_bus_protocol_engine.sv */
`timescale 1ns/1ps
module i2c_bus_protocol_engine (
    input wire logic sys_clk, // system clock
    input wire logic reset, // asynchronous, active high
    input wire logic linkClk, // bus-side sampling clock
    input wire logic enable, // engine on
    input wire logic [i2c_engine_pkg::ADDR_W-1:0] ownAddr, // own address
    input wire logic gcEnable, // answer general call
    input wire logic ackEnable, // acknowledge as slave
    input wire logic cmdValid, // command offered
    output logic cmdReady, // command can be taken
    input wire logic [2:0] cmdOp, // command code
    input wire logic [7:0] cmdData, // address or data byte
    input wire logic cmdAck, // ack bit to give after a read byte (0 = ack)
    output logic evtValid, // event pulse
    output logic [1:0] evtKind, // event code
    output logic [7:0] evtData, // byte seen on the bus
    output logic evtAck, // ack bit seen (0 = ack)
    output logic busBusy, // bus between START and STOP
    output logic masterMode, // engine owns the bus
    output logic slaveAddressed, // addressed as slave
    output logic slaveTransmit, // addressed slave transmitter
    input wire logic sclIn, // clock line level
    output logic sclOut, // clock line drive value
    output logic sclOe, // clock line pulled low
    input wire logic sdaIn, // data line level
    output logic sdaOut, // data line drive value
    output logic sdaOe // data line pulled low
);

    //**************************************************************
    // state
    //**************************************************************

    typedef struct packed {
        i2c_engine_pkg::mstate_e mst;
        i2c_engine_pkg::role_e role;
        logic busy;
        logic master;
        logic addrByte;
        logic mRead;
        logic sendAck;
        logic ownBit;
        logic ackSeen;
        logic [3:0] cnt;
        logic [7:0] rxSh;
        logic [7:0] txByte;
        logic [4:0] qCnt;
        logic half;
        logic sclOe;
        logic sdaOe;
        logic prevScl;
        logic prevSda;
        logic reqSeen;
        logic evTgl;
        i2c_engine_pkg::event_e evKind;
        logic [7:0] evData;
        logic evAck;
    } lk_s;

    typedef struct packed {
        logic reqTgl;
        i2c_engine_pkg::op_e op;
        logic [7:0] data;
        logic ack;
        logic evSeen;
        logic evtValid;
        i2c_engine_pkg::event_e evtKind;
        logic [7:0] evtData;
        logic evtAck;
    } sy_s;

    localparam int LK_SYNC_W = i2c_engine_pkg::ADDR_W + 6;

    lk_s lk_q;
    lk_s lk_d;
    sy_s sy_q;
    sy_s sy_d;

    logic [LK_SYNC_W-1:0] lkSync;
    logic [5:0] sySync;
    logic sclS;
    logic sdaS;
    logic reqS;
    logic cfgEn;
    logic gcEn;
    logic ackEn;
    logic [i2c_engine_pkg::ADDR_W-1:0] ownA;
    logic rise;
    logic fall;
    logic startDet;
    logic stopDet;
    logic qDone;
    logic reqNew;
    logic holdReady;
    logic idleDrop;
    logic txing;

    //**************************************************************
    // crossings
    //**************************************************************

    sync_2ff #(
        .WIDTH(LK_SYNC_W)
    ) linkSide (
        .clk(linkClk),
        .reset(reset),
        .d({sy_q.reqTgl, enable, gcEnable, ackEnable, ownAddr,
            sclIn, sdaIn}),
        .q(lkSync)
    );

    sync_2ff #(
        .WIDTH(6)
    ) sysSide (
        .clk(sys_clk),
        .reset(reset),
        .d({lk_q.reqSeen, lk_q.evTgl, lk_q.busy, lk_q.master,
            lk_q.role}),
        .q(sySync)
    );

    assign {reqS, cfgEn, gcEn, ackEn, ownA, sclS, sdaS} = lkSync;
    assign busBusy = sySync[3];
    assign masterMode = sySync[2];
    assign slaveAddressed = sySync[0];
    assign slaveTransmit = sySync[1];

    //**************************************************************
    // link side engine
    //**************************************************************

    always_comb
    begin
        lk_d = lk_q;
        rise = ~lk_q.prevScl & sclS;
        fall = lk_q.prevScl & ~sclS;
        startDet = lk_q.prevScl & sclS & lk_q.prevSda & ~sdaS; // R01
        stopDet = lk_q.prevScl & sclS & ~lk_q.prevSda & sdaS; // R02
        qDone = lk_q.qCnt == i2c_engine_pkg::QUARTER_LAST;
        reqNew = reqS != lk_q.reqSeen;
        holdReady = (lk_q.mst == i2c_engine_pkg::M_HOLD)
            & (lk_q.cnt == i2c_engine_pkg::CNT_ZERO);
        idleDrop = (lk_q.mst == i2c_engine_pkg::M_IDLE) & ~lk_q.master;
        txing = (lk_q.master & (lk_q.addrByte | ~lk_q.mRead)) // R08
            | (lk_q.role == i2c_engine_pkg::R_STX);
        // lines read idle-high until enabled: no false edge after reset
        lk_d.prevScl = sclS | ~cfgEn;
        lk_d.prevSda = sdaS | ~cfgEn;
        lk_d.qCnt = qDone ? 5'h00 : lk_q.qCnt + 5'h01;
        lk_d.half = lk_q.half ^ qDone;

        // bit sequencing on observed clock edges
        if (fall)
        begin
            lk_d.ownBit = 1'h0;
            if (lk_q.cnt == i2c_engine_pkg::BIT_END)
            begin
                lk_d.cnt = i2c_engine_pkg::CNT_ZERO;
                lk_d.sdaOe = 1'h0;
                if ((lk_q.role == i2c_engine_pkg::R_STX) & ~lk_q.ackSeen)
                    lk_d.sdaOe = ~lk_q.txByte[i2c_engine_pkg::MSB_BIT];
            end
            else if (lk_q.cnt < i2c_engine_pkg::BIT_ACK)
            begin
                lk_d.sdaOe = txing & ~lk_q.txByte[~lk_q.cnt[2:0]]; // R10
                lk_d.ownBit = lk_q.master & txing; // R21
            end
            else
            begin
                lk_d.sdaOe = 1'h0; // R12
                if (lk_q.master & ~lk_q.addrByte & lk_q.mRead)
                begin
                    lk_d.sdaOe = ~lk_q.sendAck; // R16
                    lk_d.ownBit = 1'h1; // R21
                end
                else if (~lk_q.master & lk_q.addrByte)
                begin
                    if (lk_q.rxSh[i2c_engine_pkg::BYTE_W-1:
                            i2c_engine_pkg::RW_BIT+1] == ownA)
                    begin
                        if (ackEn) // R14
                        begin
                            lk_d.sdaOe = 1'h1; // R13
                            lk_d.role = lk_q.rxSh[i2c_engine_pkg::RW_BIT]
                                ? i2c_engine_pkg::R_STX
                                : i2c_engine_pkg::R_SRX; // R07 R20
                            lk_d.evTgl = ~lk_q.evTgl; // R25
                            lk_d.evKind = i2c_engine_pkg::EV_ADDR;
                            lk_d.evData = lk_q.rxSh;
                            lk_d.evAck = 1'h0;
                        end
                    end
                    else if ((lk_q.rxSh == i2c_engine_pkg::GC_ADDR) & gcEn)
                    begin
                        lk_d.sdaOe = 1'h1; // R09
                        lk_d.role = i2c_engine_pkg::R_SRX; // R09
                        lk_d.evTgl = ~lk_q.evTgl; // R25
                        lk_d.evKind = i2c_engine_pkg::EV_GCALL;
                        lk_d.evData = lk_q.rxSh;
                        lk_d.evAck = 1'h0;
                    end
                end
                else if (lk_q.role == i2c_engine_pkg::R_SRX)
                begin
                    lk_d.sdaOe = ackEn; // R13
                    if (~ackEn)
                        lk_d.role = i2c_engine_pkg::R_IDLE; // R15
                end
            end
        end

        if (rise)
        begin
            if (lk_q.cnt < i2c_engine_pkg::BIT_ACK)
            begin
                lk_d.rxSh = {lk_q.rxSh[i2c_engine_pkg::BYTE_W-2:0],
                    sdaS}; // R23
                lk_d.cnt = lk_q.cnt + 4'h1;
            end
            else if (lk_q.cnt == i2c_engine_pkg::BIT_ACK)
            begin
                lk_d.cnt = i2c_engine_pkg::BIT_END; // R11
                lk_d.ackSeen = sdaS;
                lk_d.addrByte = 1'h0;
                if (lk_q.master & lk_q.addrByte)
                    lk_d.mRead = lk_q.txByte[i2c_engine_pkg::RW_BIT]; // R07
                if ((lk_q.role == i2c_engine_pkg::R_STX) & sdaS)
                    lk_d.role = i2c_engine_pkg::R_IDLE; // R16
                lk_d.evTgl = ~lk_q.evTgl;
                lk_d.evKind = i2c_engine_pkg::EV_BYTE;
                lk_d.evData = lk_q.rxSh;
                lk_d.evAck = sdaS;
            end
        end

        // arbitration: only a master checks its own high bits
        if (lk_q.master & lk_q.ownBit & ~lk_q.sdaOe & lk_q.prevScl
            & sclS & ~sdaS) // R18 R22
        begin
            lk_d.master = 1'h0; // R19
            lk_d.sdaOe = 1'h0; // R18
            lk_d.ownBit = 1'h0;
            lk_d.role = i2c_engine_pkg::R_IDLE; // R19
            lk_d.evTgl = ~lk_q.evTgl; // R25
            lk_d.evKind = i2c_engine_pkg::EV_ARB;
            lk_d.evData = lk_q.rxSh;
            lk_d.evAck = 1'h1;
        end

        // master clock generator
        unique case (lk_q.mst)
            i2c_engine_pkg::M_IDLE,
            i2c_engine_pkg::M_HOLD:
                lk_d.mst = lk_q.mst;
            i2c_engine_pkg::M_START:
                if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_LOW;
                    lk_d.sclOe = 1'h1; // R01
                end
            i2c_engine_pkg::M_LOW:
                if (qDone & lk_q.half)
                begin
                    lk_d.mst = i2c_engine_pkg::M_HIGH;
                    lk_d.sclOe = 1'h0;
                end
            i2c_engine_pkg::M_HIGH:
                if (~sclS)
                begin
                    lk_d.qCnt = 5'h00; // R24
                    lk_d.half = lk_q.half;
                end
                else if (qDone & lk_q.half)
                begin
                    if (lk_q.cnt != i2c_engine_pkg::BIT_END)
                    begin
                        lk_d.mst = i2c_engine_pkg::M_LOW;
                        lk_d.sclOe = 1'h1;
                    end
                    else if (lk_q.master)
                    begin
                        lk_d.mst = i2c_engine_pkg::M_HOLD;
                        lk_d.sclOe = 1'h1;
                    end
                    else
                        lk_d.mst = i2c_engine_pkg::M_IDLE; // R19
                end
            i2c_engine_pkg::M_RS1:
                if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_RS2;
                    lk_d.sclOe = 1'h0;
                end
            i2c_engine_pkg::M_RS2:
                if (~sclS)
                    lk_d.qCnt = 5'h00;
                else if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_START;
                    lk_d.sdaOe = 1'h1; // R05
                end
            i2c_engine_pkg::M_STOP1:
                if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_STOP2;
                    lk_d.sclOe = 1'h0;
                end
            i2c_engine_pkg::M_STOP2:
                if (~sclS)
                    lk_d.qCnt = 5'h00;
                else if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_STOP3;
                    lk_d.sdaOe = 1'h0; // R02
                end
            i2c_engine_pkg::M_STOP3:
                if (qDone)
                begin
                    lk_d.mst = i2c_engine_pkg::M_IDLE;
                    lk_d.master = 1'h0;
                end
            default:
                lk_d.mst = i2c_engine_pkg::M_IDLE;
        endcase

        // commands from the system side
        if (reqNew & cfgEn)
        begin
            unique case (sy_q.op)
                i2c_engine_pkg::OP_START:
                    if (idleDrop & ~lk_q.busy & sclS & sdaS) // R17
                    begin
                        lk_d.reqSeen = reqS;
                        lk_d.master = 1'h1;
                        lk_d.mRead = 1'h0;
                        lk_d.txByte = sy_q.data; // R06
                        lk_d.sdaOe = 1'h1; // R01
                        lk_d.mst = i2c_engine_pkg::M_START;
                    end
                    else if (holdReady)
                    begin
                        lk_d.reqSeen = reqS;
                        lk_d.mRead = 1'h0;
                        lk_d.txByte = sy_q.data; // R06
                        lk_d.sdaOe = 1'h0;
                        lk_d.mst = i2c_engine_pkg::M_RS1; // R05
                    end
                i2c_engine_pkg::OP_WRITE,
                i2c_engine_pkg::OP_READ:
                    if (holdReady)
                    begin
                        lk_d.reqSeen = reqS;
                        lk_d.txByte = sy_q.data;
                        lk_d.sendAck = sy_q.ack;
                        lk_d.sdaOe = ~lk_q.mRead
                            & ~sy_q.data[i2c_engine_pkg::MSB_BIT];
                        lk_d.ownBit = ~lk_q.mRead;
                        lk_d.mst = i2c_engine_pkg::M_LOW;
                    end
                    else if (idleDrop)
                        lk_d.reqSeen = reqS;
                i2c_engine_pkg::OP_STOP:
                    if (holdReady)
                    begin
                        lk_d.reqSeen = reqS;
                        lk_d.sdaOe = 1'h1;
                        lk_d.mst = i2c_engine_pkg::M_STOP1;
                    end
                    else if (idleDrop)
                        lk_d.reqSeen = reqS;
                default:
                begin
                    lk_d.reqSeen = reqS;
                    if (~lk_q.master & (sy_q.op == i2c_engine_pkg::OP_LOAD))
                        lk_d.txByte = sy_q.data;
                end
            endcase
        end

        if (lk_d.mst != lk_q.mst)
        begin
            lk_d.qCnt = 5'h00;
            lk_d.half = 1'h0;
        end

        // bus conditions seen from anyone, own ones included
        if (startDet)
        begin
            lk_d.busy = 1'h1; // R03
            lk_d.cnt = i2c_engine_pkg::CNT_ZERO;
            lk_d.addrByte = 1'h1; // R06
            if (~lk_q.master)
                lk_d.role = i2c_engine_pkg::R_IDLE;
        end
        if (stopDet)
        begin
            lk_d.busy = 1'h0; // R03
            lk_d.cnt = i2c_engine_pkg::CNT_ZERO;
            lk_d.addrByte = 1'h0;
            lk_d.master = 1'h0; // R04
            lk_d.role = i2c_engine_pkg::R_IDLE; // R04
            lk_d.mst = i2c_engine_pkg::M_IDLE;
            lk_d.sclOe = 1'h0;
            lk_d.sdaOe = 1'h0;
        end

        // disabled: lines released, commands drained
        if (~cfgEn)
        begin
            lk_d.mst = i2c_engine_pkg::M_IDLE;
            lk_d.role = i2c_engine_pkg::R_IDLE;
            lk_d.busy = 1'h0;
            lk_d.master = 1'h0;
            lk_d.addrByte = 1'h0;
            lk_d.cnt = i2c_engine_pkg::CNT_ZERO;
            lk_d.sclOe = 1'h0;
            lk_d.sdaOe = 1'h0;
            lk_d.reqSeen = reqS;
        end
    end

    always_ff @(posedge linkClk or posedge reset)
    begin
        if (reset)
            lk_q <= '0;
        else
            lk_q <= lk_d;
    end

    assign sclOut = 1'h0;
    assign sdaOut = 1'h0;
    assign sclOe = lk_q.sclOe;
    assign sdaOe = lk_q.sdaOe;

    //**************************************************************
    // system side
    //**************************************************************

    assign cmdReady = sy_q.reqTgl == sySync[5];

    always_comb
    begin
        sy_d = sy_q;
        sy_d.evtValid = 1'h0;
        if (cmdValid & cmdReady)
        begin
            sy_d.reqTgl = ~sy_q.reqTgl;
            sy_d.op = i2c_engine_pkg::op_e'(cmdOp);
            sy_d.data = cmdData;
            sy_d.ack = cmdAck;
        end
        // event fields are stable in the link domain when the toggle lands
        if (sySync[4] != sy_q.evSeen)
        begin
            sy_d.evSeen = sySync[4];
            sy_d.evtValid = 1'h1; // R25
            sy_d.evtKind = lk_q.evKind;
            sy_d.evtData = lk_q.evData;
            sy_d.evtAck = lk_q.evAck;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            sy_q <= '0;
        else
            sy_q <= sy_d;
    end

    assign evtValid = sy_q.evtValid;
    assign evtKind = sy_q.evtKind;
    assign evtData = sy_q.evtData;
    assign evtAck = sy_q.evtAck;

endmodule

/* core/i2c_engine_pkg.sv */
// Behaviour
// R01 - START is data falling while clock high; detected and generated so.
// R02 - STOP is data rising while clock high; detected and generated so.
// R03 - Bus is busy after any START and free after any STOP.
// R04 - After STOP the master and any addressed slave become not addressed.
// R05 - Master may send repeated START instead of STOP and readdress.
// R06 - First byte after START holds 7-bit address plus direction bit.
// R07 - Direction 0 means master writes, 1 means master reads.
// R08 - Later bytes come from master or slave as the direction bit says.
// R09 - All-zero first byte is general call, acknowledged only when enabled.
// R10 - Data changes only while the clock line is low.
// R11 - Ninth clock of each byte is the acknowledge clock, made by master.
// R12 - Transmitter releases data line during the acknowledge clock.
// R13 - Receiver acknowledges by pulling data low during ninth clock high.
// R14 - Slave not acknowledging its address leaves data high.
// R15 - Slave receiver refusing data becomes not addressed, data left high.
// R16 - Master receiver skips last acknowledge; slave transmitter then lets go.
// R17 - A transfer as master starts only while the bus is free.
// R18 - Master driving high but reading low loses and stops driving data.
// R19 - Loser releases data, becomes slave, keeps clocking to byte end.
// R20 - Loser addressed by the winner becomes an addressed slave.
// R21 - Arbitration runs through address, data and acknowledge bits.
// R22 - A device acting only as slave never sees arbitration loss.
// R23 - Each byte is eight bits MSB first plus one acknowledge bit.
// R24 - A receiver may stretch the clock low; master waits for release.
// R25 - Arbitration loss, address match, general call are reported as events.
package i2c_engine_pkg;

    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int MSB_BIT = 7;
    localparam int RW_BIT = 0;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [7:0] GC_ADDR = 8'h00;

    // bus clock quarter period, derived from link clock rate
    localparam int LINK_CLK_NS = 160;
    localparam int SCL_QUARTER_NS = 2500;
    localparam logic [4:0] QUARTER_CYC =
        5'((SCL_QUARTER_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [4:0] QUARTER_LAST = QUARTER_CYC - 5'h01;

    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_START = 4'h1,
        M_LOW = 4'h2,
        M_HIGH = 4'h3,
        M_HOLD = 4'h4,
        M_RS1 = 4'h5,
        M_RS2 = 4'h6,
        M_STOP1 = 4'h7,
        M_STOP2 = 4'h8,
        M_STOP3 = 4'h9
    } mstate_e;

    typedef enum logic [1:0] {
        R_IDLE = 2'h0,
        R_SRX = 2'h1,
        R_STX = 2'h3
    } role_e;

    typedef enum logic [2:0] {
        OP_START = 3'h0,
        OP_WRITE = 3'h1,
        OP_READ = 3'h2,
        OP_STOP = 3'h3,
        OP_LOAD = 3'h4
    } op_e;

    typedef enum logic [1:0] {
        EV_BYTE = 2'h0,
        EV_ARB = 2'h1,
        EV_ADDR = 2'h2,
        EV_GCALL = 2'h3
    } event_e;

endpackage

/* core/sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // destination clock
    input wire logic reset, // asynchronous, active high
    input wire logic [WIDTH-1:0] d, // signals from another domain
    output logic [WIDTH-1:0] q // synchronised copy
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } st_s;

    st_s st_q;
    st_s st_d;

    always_comb
    begin
        st_d.meta = d;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign q = st_q.sync;

endmodule

/* testbench/i2c_engine_asserts.sv */
`timescale 1ns/1ps
module i2c_engine_asserts (
    input wire logic sys_clk, // system clock
    input wire logic reset, // reset
    input wire logic linkClk, // link clock
    input wire logic [6:0] ownAddr, // own address
    input wire logic evtValid, // event pulse
    input wire logic [1:0] evtKind, // event code
    input wire logic [7:0] evtData, // event byte
    input wire logic busBusy, // bus busy
    input wire logic masterMode, // owns bus
    input wire logic slaveAddressed, // addressed
    input wire logic sclIn, // clock line
    input wire logic sdaIn // data line
);
    sequence cond_s(e);
        e && sclIn && $past(sclIn);
    endsequence
    a_busy_on: assert property (@(posedge linkClk) disable iff (reset)
        cond_s($fell(sdaIn)) |-> ##[1:10] busBusy) else $error("not busy");
    a_stop_free: assert property (@(posedge linkClk) disable iff (reset)
        cond_s($rose(sdaIn)) |-> ##[1:10] !busBusy) else $error("not free");
    a_stop_owner: assert property (@(posedge linkClk) disable iff (reset)
        cond_s($rose(sdaIn)) |-> ##[1:10] !masterMode) else $error("owner");
    a_stop_addr: assert property (@(posedge linkClk) disable iff (reset)
        cond_s($rose(sdaIn)) |-> ##[1:10] !slaveAddressed) else $error("addr");
    a_evt_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        evtValid |=> !evtValid) else $error("event too long");
    a_addr_evt: assert property (@(posedge sys_clk) disable iff (reset)
        evtValid && evtKind == 2'h2 |-> evtData[7:1] == ownAddr)
        else $error("address event wrong");
    a_gcall_evt: assert property (@(posedge sys_clk) disable iff (reset)
        evtValid && evtKind == 2'h3 |-> evtData == 8'h00)
        else $error("general call event wrong");
    a_addr_busy: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(slaveAddressed) |-> busBusy) else $error("addressed on free bus");
endmodule
bind i2c_bus_protocol_engine i2c_engine_asserts chk (
    .sys_clk, .reset, .linkClk, .ownAddr, .evtValid, .evtKind, .evtData,
    .busBusy, .masterMode, .slaveAddressed, .sclIn, .sdaIn
);

/* testbench/i2c_slave_model.sv */
`timescale 1ns/1ps
module i2c_slave_model #(
    parameter logic [6:0] SLV = 7'h50
) (
    input wire logic scl, // clock line
    input wire logic sda, // data line
    input wire logic [7:0] txByte, // read data
    output logic sdaOe = 1'b0 // pulls data low
);
    logic [3:0] n;
    logic [7:0] sh;
    logic act = 1'b0, rd, first;
    always @(negedge sda)
        if (scl)
            {act, rd, first, n} = {3'b101, 4'hF};
    always @(posedge sda)
        if (scl)
            act = 1'b0;
    always @(posedge scl)
        if (act && n < 4'h8)
            sh = {sh[6:0], sda};
        else if (act && rd && !first && sda)
            act = 1'b0;
    always @(negedge scl)
        if (act)
        begin
            n = n + 4'h1;
            if (n == 4'h8 && first)
                {act, rd} = {sh[7:1] == SLV, sh[0]};
            if (n == 4'h9)
                {n, first} = 5'h00;
            sdaOe = act && (n == 4'h8 ? !rd || first
                : rd && !txByte[3'h7 - n[2:0]]);
        end
endmodule

/* testbench/i2c_bus_protocol_engine_test.sv */
`timescale 1ns/1ps
module i2c_bus_protocol_engine_test;
    logic sys_clk = 1'b0, linkClk = 1'b0, reset = 1'b0, a;
    logic cmdValid = 1'b0, cmdAck = 1'b0, tbScl = 1'b0, tbSda = 1'b0;
    logic [2:0] cmdOp = 3'h0;
    logic [7:0] cmdData = 8'h00, evtData;
    logic [1:0] evtKind;
    logic cmdReady, evtValid, evtAck, busBusy, masterMode;
    logic slaveAddressed, slaveTransmit, sclOe, sdaOe, slvOe;
    logic ackEnable = 1'b1;
    int fails = 0, tests_run = 0;
    wire scl = !(sclOe | tbScl);
    wire sda = !(sdaOe | tbSda | slvOe);
    i2c_bus_protocol_engine dut (
        .sys_clk, .reset, .linkClk, .enable(1'b1), .ownAddr(7'h2C),
        .gcEnable(1'b1), .ackEnable, .cmdValid, .cmdReady, .cmdOp,
        .cmdData, .cmdAck, .evtValid, .evtKind, .evtData, .evtAck,
        .busBusy, .masterMode, .slaveAddressed, .slaveTransmit,
        .sclIn(scl), .sclOut(), .sclOe, .sdaIn(sda), .sdaOut(), .sdaOe
    );
    i2c_slave_model #(.SLV(7'h50)) peer (.scl, .sda, .txByte(8'hA5),
        .sdaOe(slvOe));
    initial forever #4 sys_clk = ~sys_clk;
    initial #3 forever #80 linkClk = ~linkClk;
    task chk(string nm, logic [7:0] e, s);
        tests_run++;
        if (e !== s)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cmd(logic [2:0] op, logic [7:0] d, logic ak);
        @(posedge sys_clk);
        {cmdValid, cmdOp, cmdData, cmdAck} <= {1'b1, op, d, ak};
        do @(negedge sys_clk); while (cmdReady !== 1'b1);
        @(posedge sys_clk);
        cmdValid <= 1'b0;
    endtask
    task evt(logic [1:0] k, logic [7:0] d, logic ak);
        do @(negedge sys_clk); while (evtValid !== 1'b1);
        chk("evtKind", 8'(k), 8'(evtKind));
        chk("evtData", d, evtData);
        chk("evtAck", 8'(ak), 8'(evtAck));
    endtask
    task w;
        repeat (8) @(posedge linkClk);
    endtask
    // external master: START (or data byte) with ack clock, or STOP
    // a holds the ack
    task bang(logic [7:0] b, logic stop);
        tbSda <= 1'b1;
        w;
        tbScl <= !stop;
        for (int i = 7; i >= -1 && !stop; i--)
        begin
            w;
            tbSda <= i >= 0 && !b[3'(i)];
            w;
            tbScl <= 1'b0;
            w;
            a = sda;
            tbScl <= 1'b1;
        end
        w;
        tbSda <= 1'b0;
        w;
    endtask
    task stop_wait;
        cmd(3'h3, 8'h00, 1'b0);
        do @(negedge sys_clk); while (busBusy !== 1'b0);
        chk("masterMode", 8'h00, 8'(masterMode));
    endtask
    task s_master;
        cmd(3'h0, 8'hA0, 1'b0);
        evt(2'h0, 8'hA0, 1'b0);
        chk("busBusy", 8'h01, 8'(busBusy));
        cmd(3'h1, 8'h3C, 1'b0);
        evt(2'h0, 8'h3C, 1'b0);
        chk("peerByte", 8'h3C, peer.sh);
        cmd(3'h0, 8'hA1, 1'b0);
        evt(2'h0, 8'hA1, 1'b0);
        cmd(3'h2, 8'h00, 1'b1);
        evt(2'h0, 8'hA5, 1'b1);
        stop_wait;
    endtask
    task s_nack;
        cmd(3'h0, 8'hA2, 1'b0);
        evt(2'h0, 8'hA2, 1'b1);
        stop_wait;
    endtask
    task s_slave;
        fork
            bang(8'h58, 1'b0);
            evt(2'h2, 8'h58, 1'b0);
        join
        chk("ownAck", 8'h00, 8'(a));
        chk("addressed", 8'h01, 8'(slaveAddressed));
        chk("slaveTx", 8'h00, 8'(slaveTransmit));
        @(posedge sys_clk) ackEnable <= 1'b0;
        bang(8'h3C, 1'b0);
        chk("dataNak", 8'h01, 8'(a));
        chk("dropped", 8'h00, 8'(slaveAddressed));
        @(posedge sys_clk) ackEnable <= 1'b1;
        bang(8'h00, 1'b1);
        chk("addressed", 8'h00, 8'(slaveAddressed));
        fork
            bang(8'h00, 1'b0);
            evt(2'h3, 8'h00, 1'b0);
        join
        chk("gcallAck", 8'h00, 8'(a));
        bang(8'h00, 1'b1);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        s_master;
        s_nack;
        s_slave;
        tally_and_finish;
    end
    initial
    begin
        #780000;
        fails++;
        tally_and_finish;
    end
endmodule
